// ==== verilog/gpio_map.svh ====
`ifndef GPIO_MAP_SVH
`define GPIO_MAP_SVH
// ----------------------------------------
// offsets inside the port window
// ----------------------------------------
`define OFS_P1_VALUE 3'h0
`define OFS_P1_DIR 3'h1
`define OFS_P1_DRV 3'h2
`define OFS_P1_PULL 3'h3
`define OFS_P2_VALUE 3'h4
`define OFS_P2_DIR 3'h5
`define OFS_P2_DRV 3'h6
`define OFS_P2_PULL 3'h7
`define OFS_P1_LOCK 3'h0
`define OFS_P1_POL 3'h1
`define OFS_P1_ROUTE 3'h2
`define OFS_B1_RSVD 3'h3
`define OFS_P3_VALUE 3'h4
`define OFS_P3_DIR 3'h5
`define OFS_P3_DRV 3'h6
`define OFS_P3_PULL 3'h7
// ----------------------------------------
// reset values and fields
// ----------------------------------------
`define RST_VALUE 8'hff
`define RST_DIR 8'h00
`define RST_DRV 8'h00
`define RST_PULL 8'hff
`define RST_LOCK 4'h0
`define RST_POL 1'h0
`define RST_ROUTE 1'h0
`define RST_PIN_SYNC 8'hff
`define LOCK_LSB 4
`define LOCK_MSB 7
`endif

// ==== verilog/gpio_pkg.sv ====
package gpio_pkg;
  typedef struct packed {
    logic [7:0] value;
    logic [7:0] dir;
    logic [7:0] drv;
    logic [7:0] pull;
  } port_cfg_t;

  typedef struct packed {
    logic [7:0] out;
    logic [7:0] oe;
    logic [7:0] pull;
  } pin_drive_t;
endpackage

// ==== verilog/port_pad_logic.sv ====
`timescale 1ns/100ps
// ----------------------------------------
// per-port pin driver: open-drain or push-pull
// ----------------------------------------
module port_pad_logic
  import gpio_pkg::*;
(
  input wire port_cfg_t cfg,
  input wire logic [7:0] level,
  output pin_drive_t drive
);
  // open-drain drives only a low; a high is left to the pull-up
  always_comb begin
    drive.out = level;
    drive.oe = cfg.dir & (cfg.drv | ~level);
    drive.pull = cfg.pull;
  end
endmodule

// ==== verilog/banked_gpio_ports.sv ====
`timescale 1ns/100ps
`include "gpio_map.svh"
// How it works
// - data read gives pin if input, latch if output
// - data writes latch; reset all ones
// - direction bit one means output; reset zero
// - driver type zero open-drain, one push-pull
// - pull-up bit one enables pull-up; reset ones
// - bank 0 holds ports 1 and 2
// - bank 1 offsets 4 to 7 hold port 3
// - lock bits 7-4 freeze settings of port 1 pins 7-4
// - locked output bit also freezes data bit
// - lock bits clear only by hard reset
// - polarity bit 0 sets pin 0 active level
// - route pin 0 to pin 1 when enabled and port 1 data bit 1 is zero
// - lock low bits, bank 1 offset 3 reserved
// - bank select input chooses visible bank
// - routed pin 1 low when pin 0 inactive
// - input-bit writes latch, appear on direction change
module banked_gpio_ports
  import gpio_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic bank_select,
  input wire logic [2:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  input wire logic [7:0] port1_pin_in,
  input wire logic [7:0] port2_pin_in,
  input wire logic [7:0] port3_pin_in,
  output pin_drive_t port1_drive,
  output pin_drive_t port2_drive,
  output pin_drive_t port3_drive
);
  // ----------------------------------------
  // state
  // ----------------------------------------
  logic [7:0] p1_value_r, p1_dir_r, p1_drv_r, p1_pull_r;
  logic [7:0] p2_value_r, p2_dir_r, p2_drv_r, p2_pull_r;
  logic [7:0] p3_value_r, p3_dir_r, p3_drv_r, p3_pull_r;
  port_cfg_t p1_cfg, p2_cfg, p3_cfg;
  logic [3:0] lock_r;
  logic pol_r;
  logic route_r;
  logic [7:0] p1_meta_r, p1_sync_r;
  logic [7:0] p2_meta_r, p2_sync_r;
  logic [7:0] p3_meta_r, p3_sync_r;
  logic [7:0] rdata_nxt;
  logic [7:0] lock_mask;
  logic [7:0] data_frz;
  logic wr0, wr1;
  logic p1_value_we, p1_dir_we, p1_drv_we, p1_pull_we;
  logic p2_value_we, p2_dir_we, p2_drv_we, p2_pull_we;
  logic p3_value_we, p3_dir_we, p3_drv_we, p3_pull_we;
  logic lock_we, pol_we, route_we;
  logic route_on;
  logic pin0_active;
  logic [7:0] p1_level;
  pin_drive_t p1_pad;

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic [7:0] read_value(input port_cfg_t c, input logic [7:0] pins);
    read_value = (c.dir & c.value) | (~c.dir & pins);
  endfunction

  // a frozen bit keeps its old value, the others take the write
  function automatic logic [7:0] merge(input logic [7:0] old, input logic [7:0] nw,
                                       input logic [7:0] frz);
    merge = (old & frz) | (nw & ~frz);
  endfunction

  function automatic logic wr_hit(input logic bank_wr, input logic [2:0] addr,
                                  input logic [2:0] ofs);
    wr_hit = bank_wr & (addr == ofs);
  endfunction

  // ----------------------------------------
  // write decode
  // ----------------------------------------
  // host picks the bank first; the same offset selects a different register in each bank
  assign wr0 = reg_wr & ~bank_select;
  assign wr1 = reg_wr & bank_select;
  assign p1_value_we = wr_hit(wr0, reg_addr, `OFS_P1_VALUE);
  assign p1_dir_we = wr_hit(wr0, reg_addr, `OFS_P1_DIR);
  assign p1_drv_we = wr_hit(wr0, reg_addr, `OFS_P1_DRV);
  assign p1_pull_we = wr_hit(wr0, reg_addr, `OFS_P1_PULL);
  assign p2_value_we = wr_hit(wr0, reg_addr, `OFS_P2_VALUE);
  assign p2_dir_we = wr_hit(wr0, reg_addr, `OFS_P2_DIR);
  assign p2_drv_we = wr_hit(wr0, reg_addr, `OFS_P2_DRV);
  assign p2_pull_we = wr_hit(wr0, reg_addr, `OFS_P2_PULL);
  assign lock_we = wr_hit(wr1, reg_addr, `OFS_P1_LOCK);
  assign pol_we = wr_hit(wr1, reg_addr, `OFS_P1_POL);
  assign route_we = wr_hit(wr1, reg_addr, `OFS_P1_ROUTE);
  assign p3_value_we = wr_hit(wr1, reg_addr, `OFS_P3_VALUE);
  assign p3_dir_we = wr_hit(wr1, reg_addr, `OFS_P3_DIR);
  assign p3_drv_we = wr_hit(wr1, reg_addr, `OFS_P3_DRV);
  assign p3_pull_we = wr_hit(wr1, reg_addr, `OFS_P3_PULL);

  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  // reset to the pulled-up idle level so an early read sees no false low
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      p1_meta_r <= `RST_PIN_SYNC;
      p1_sync_r <= `RST_PIN_SYNC;
    end else begin
      p1_meta_r <= port1_pin_in;
      p1_sync_r <= p1_meta_r;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      p2_meta_r <= `RST_PIN_SYNC;
      p2_sync_r <= `RST_PIN_SYNC;
    end else begin
      p2_meta_r <= port2_pin_in;
      p2_sync_r <= p2_meta_r;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      p3_meta_r <= `RST_PIN_SYNC;
      p3_sync_r <= `RST_PIN_SYNC;
    end else begin
      p3_meta_r <= port3_pin_in;
      p3_sync_r <= p3_meta_r;
    end
  end

  // ----------------------------------------
  // lock, polarity and routing
  // ----------------------------------------
  assign lock_mask = {lock_r, 4'h0};
  assign data_frz = lock_mask & p1_dir_r;

  // lock bits only ever set; writing 0 does nothing
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      lock_r <= `RST_LOCK;
    end else if (lock_we) begin
      lock_r <= lock_r | reg_wdata[`LOCK_MSB:`LOCK_LSB];
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      pol_r <= `RST_POL;
    end else if (pol_we) begin
      pol_r <= reg_wdata[0];
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      route_r <= `RST_ROUTE;
    end else if (route_we) begin
      route_r <= reg_wdata[0];
    end
  end

  // ----------------------------------------
  // port 1 (bank 0, offsets 0..3)
  // ----------------------------------------
  // the lock works bit by bit, so every port 1 write merges
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      p1_value_r <= `RST_VALUE;
    end else if (p1_value_we) begin
      p1_value_r <= merge(p1_value_r, reg_wdata, data_frz);
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      p1_dir_r <= `RST_DIR;
    end else if (p1_dir_we) begin
      p1_dir_r <= merge(p1_dir_r, reg_wdata, lock_mask);
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      p1_drv_r <= `RST_DRV;
    end else if (p1_drv_we) begin
      p1_drv_r <= merge(p1_drv_r, reg_wdata, lock_mask);
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      p1_pull_r <= `RST_PULL;
    end else if (p1_pull_we) begin
      p1_pull_r <= merge(p1_pull_r, reg_wdata, lock_mask);
    end
  end

  // ----------------------------------------
  // port 2 (bank 0, offsets 4..7)
  // ----------------------------------------
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      p2_value_r <= `RST_VALUE;
    end else if (p2_value_we) begin
      p2_value_r <= reg_wdata;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      p2_dir_r <= `RST_DIR;
    end else if (p2_dir_we) begin
      p2_dir_r <= reg_wdata;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      p2_drv_r <= `RST_DRV;
    end else if (p2_drv_we) begin
      p2_drv_r <= reg_wdata;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      p2_pull_r <= `RST_PULL;
    end else if (p2_pull_we) begin
      p2_pull_r <= reg_wdata;
    end
  end

  // ----------------------------------------
  // port 3 (bank 1, offsets 4..7)
  // ----------------------------------------
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      p3_value_r <= `RST_VALUE;
    end else if (p3_value_we) begin
      p3_value_r <= reg_wdata;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      p3_dir_r <= `RST_DIR;
    end else if (p3_dir_we) begin
      p3_dir_r <= reg_wdata;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      p3_drv_r <= `RST_DRV;
    end else if (p3_drv_we) begin
      p3_drv_r <= reg_wdata;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      p3_pull_r <= `RST_PULL;
    end else if (p3_pull_we) begin
      p3_pull_r <= reg_wdata;
    end
  end

  // ----------------------------------------
  // per-port settings bundles
  // ----------------------------------------
  assign p1_cfg = '{value: p1_value_r, dir: p1_dir_r, drv: p1_drv_r, pull: p1_pull_r};
  assign p2_cfg = '{value: p2_value_r, dir: p2_dir_r, drv: p2_drv_r, pull: p2_pull_r};
  assign p3_cfg = '{value: p3_value_r, dir: p3_dir_r, drv: p3_drv_r, pull: p3_pull_r};

  // ----------------------------------------
  // read mux, registered
  // ----------------------------------------
  always_comb begin
    rdata_nxt = 8'h00;
    if (!bank_select) begin
      unique case (reg_addr)
        `OFS_P1_VALUE: rdata_nxt = read_value(p1_cfg, p1_sync_r);
        `OFS_P1_DIR: rdata_nxt = p1_dir_r;
        `OFS_P1_DRV: rdata_nxt = p1_drv_r;
        `OFS_P1_PULL: rdata_nxt = p1_pull_r;
        `OFS_P2_VALUE: rdata_nxt = read_value(p2_cfg, p2_sync_r);
        `OFS_P2_DIR: rdata_nxt = p2_dir_r;
        `OFS_P2_DRV: rdata_nxt = p2_drv_r;
        `OFS_P2_PULL: rdata_nxt = p2_pull_r;
      endcase
    end else begin
      unique case (reg_addr)
        `OFS_P1_LOCK: rdata_nxt = lock_mask;
        `OFS_P1_POL: rdata_nxt = {7'h00, pol_r};
        `OFS_P1_ROUTE: rdata_nxt = {7'h00, route_r};
        `OFS_B1_RSVD: rdata_nxt = 8'h00;
        `OFS_P3_VALUE: rdata_nxt = read_value(p3_cfg, p3_sync_r);
        `OFS_P3_DIR: rdata_nxt = p3_dir_r;
        `OFS_P3_DRV: rdata_nxt = p3_drv_r;
        `OFS_P3_PULL: rdata_nxt = p3_pull_r;
      endcase
    end
  end

  // reads have no side effects, so the data is simply latched on reg_rd
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      reg_rdata <= rdata_nxt;
    end
  end

  // ----------------------------------------
  // pin 0 to pin 1 routing
  // ----------------------------------------
  // pin 0 must be an input and pin 1 an output, else results are undefined
  assign route_on = route_r & ~p1_value_r[1];
  assign pin0_active = ~(p1_sync_r[0] ^ pol_r);
  assign p1_level = route_on ? {p1_value_r[7:2], pin0_active, p1_value_r[0]}
                             : p1_value_r;

  // ----------------------------------------
  // pad drivers
  // ----------------------------------------
  port_pad_logic u_pad1 (
    .cfg(p1_cfg),
    .level(p1_level),
    .drive(p1_pad)
  );

  port_pad_logic u_pad2 (
    .cfg(p2_cfg),
    .level(p2_value_r),
    .drive(port2_drive)
  );

  port_pad_logic u_pad3 (
    .cfg(p3_cfg),
    .level(p3_value_r),
    .drive(port3_drive)
  );

  assign port1_drive = p1_pad;
endmodule

// ==== tb/gpio_port_checker_properties.sv ====
`timescale 1ns/100ps
// ----------------------------------------
// port checker
// ----------------------------------------
module gpio_port_checker
  import gpio_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic bank_select,
  input wire logic [2:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire pin_drive_t port1_drive,
  input wire pin_drive_t port2_drive,
  input wire pin_drive_t port3_drive
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  logic [3:0] lock_r;
  // shadow of set lock bits; zero writes never clear them
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) lock_r <= 4'h0;
    else if (reg_wr && bank_select && reg_addr == 3'h0) lock_r <= lock_r | reg_wdata[7:4];
  end
  a_reset_no_drive: assert property ($fell(rst) |->
    (port1_drive.oe | port2_drive.oe | port3_drive.oe) == 8'h00) else $error("oe after reset");
  a_reset_pull_on: assert property ($fell(rst) |->
    (port1_drive.pull & port2_drive.pull & port3_drive.pull) == 8'hff) else $error("pull reset");
  a_rdata_holds: assert property (!reg_rd |=> $stable(reg_rdata)) else $error("rdata moved");
  a_rsvd_reads_zero: assert property (reg_rd && bank_select && reg_addr == 3'h3 |=>
    reg_rdata == 8'h00) else $error("reserved read");
  a_lock_sticky_read: assert property (reg_rd && bank_select && reg_addr == 3'h0 |=>
    reg_rdata == {lock_r, 4'h0}) else $error("lock read");
  // readback follows its write after one idle cycle
  a_p2_dir_back: assert property (reg_wr && !bank_select && reg_addr == 3'h5 ##2
    reg_rd && !bank_select && reg_addr == 3'h5 |=> reg_rdata == $past(reg_wdata, 3))
    else $error("port2 dir read");
  a_p3_pull_back: assert property (reg_wr && bank_select && reg_addr == 3'h7 ##2
    reg_rd && bank_select && reg_addr == 3'h7 |=> reg_rdata == $past(reg_wdata, 3))
    else $error("port3 pull read");
  a_p1_drv_lock: assert property (reg_wr && !bank_select && reg_addr == 3'h2 ##2
    reg_rd && !bank_select && reg_addr == 3'h2 |=> reg_rdata[3:0] == $past(reg_wdata[3:0], 3)
    && (reg_rdata[7:4] & ~lock_r) == ($past(reg_wdata[7:4], 3) & ~lock_r))
    else $error("port1 drv lock");
endmodule
bind banked_gpio_ports gpio_port_checker u_gpio_port_checker(.ref_clk(ref_clk), .rst(rst),
  .bank_select(bank_select), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .port1_drive(port1_drive),
  .port2_drive(port2_drive), .port3_drive(port3_drive));

// ==== tb/pin_model.sv ====
`timescale 1ns/100ps
// ----------------------------------------
// pin wire: device, outside driver, pull-up
// ----------------------------------------
module pin_model
  import gpio_pkg::*;
(
  input wire logic ref_clk,
  input wire pin_drive_t drive,
  input wire logic [7:0] ext_val,
  input wire logic [7:0] ext_en,
  output logic [7:0] level
);
  logic tgl_r = 1'b0;
  // a floating pin wanders so a stale level never passes for valid
  always @(posedge ref_clk) tgl_r <= ~tgl_r;
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      level[i] = drive.oe[i] ? drive.out[i] : ext_en[i] ? ext_val[i] : drive.pull[i] | tgl_r;
    end
  end
endmodule

// ==== tb/tb_top.sv ====
`timescale 1ns/100ps
module tb_top;
  import gpio_pkg::*;
  logic ref_clk = 0, rst = 1, bsel = 0, wr = 0, rd = 0;
  logic [2:0] addr = 3'h0;
  logic [7:0] wd = 8'h00, rdata, p1, p2, p3, x1 = 8'h00, x2 = 8'h00, e1 = 8'h00, e2 = 8'h00;
  pin_drive_t d1, d2, d3;
  int err_total = 0, compares = 0;
  logic [7:0] rv [16] = '{8'hff, 8'h00, 8'h00, 8'hff, 8'hff, 8'h00, 8'h00, 8'hff,
    8'h00, 8'h00, 8'h00, 8'h00, 8'hff, 8'h00, 8'h00, 8'hff};
  always #10 ref_clk = ~ref_clk;
  banked_gpio_ports u_banked_gpio_ports(.ref_clk(ref_clk), .rst(rst), .bank_select(bsel),
    .reg_addr(addr), .reg_wr(wr), .reg_rd(rd), .reg_wdata(wd), .reg_rdata(rdata),
    .port1_pin_in(p1), .port2_pin_in(p2), .port3_pin_in(p3), .port1_drive(d1),
    .port2_drive(d2), .port3_drive(d3));
  pin_model u_pin_model1(.ref_clk(ref_clk), .drive(d1), .ext_val(x1), .ext_en(e1), .level(p1));
  pin_model u_pin_model2(.ref_clk(ref_clk), .drive(d2), .ext_val(x2), .ext_en(e2), .level(p2));
  pin_model u_pin_model3(.ref_clk(ref_clk), .drive(d3), .ext_val(8'h00), .ext_en(8'h00),
    .level(p3));
  task automatic check(input string n, input logic [7:0] s, input logic [7:0] e);
    compares++;
    if (s !== e) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic wreg(input logic b, input logic [2:0] a, input logic [7:0] d);
    @(negedge ref_clk);
    bsel = b;
    addr = a;
    wd = d;
    wr = 1;
    @(negedge ref_clk);
    wr = 0;
  endtask
  task automatic rreg(input logic b, input logic [2:0] a, input logic [7:0] e);
    @(negedge ref_clk);
    bsel = b;
    addr = a;
    rd = 1;
    @(negedge ref_clk);
    rd = 0;
    check("reg_rdata", rdata, e);
  endtask
  task automatic settle();
    repeat (4) @(negedge ref_clk);
  endtask
  task automatic print_verdict();
    $display("compares %0d err_total %0d", compares, err_total);
    if (err_total == 0 && compares > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  initial begin
    #100000;
    err_total++;
    print_verdict();
  end
  initial begin
    repeat (10) @(negedge ref_clk);
    rst = 0;
    settle();
    // ----------------------------------------
    // reset values and map
    // ----------------------------------------
    for (int i = 0; i < 16; i++) rreg(i[3], i[2:0], rv[i]);
    for (int a = 1; a < 8; a++) if (a != 4) begin
      wreg(0, 3'(a), 8'h5a);
      rreg(0, 3'(a), 8'h5a);
    end
    for (int a = 5; a < 8; a++) begin
      wreg(1, 3'(a), 8'ha5);
      rreg(1, 3'(a), 8'ha5);
    end
    check("p3 oe", d3.oe, 8'ha5);
    check("p3 pull", d3.pull, 8'ha5);
    wreg(1, 4, 8'h3c);
    check("p3 out", d3.out, 8'h3c);
    // ----------------------------------------
    // port 2 data path
    // ----------------------------------------
    wreg(0, 7, 8'hff);
    wreg(0, 5, 8'h00);
    wreg(0, 4, 8'h0f);
    x2 = 8'h3c;
    e2 = 8'hff;
    settle();
    rreg(0, 4, 8'h3c);
    e2 = 8'h00;
    wreg(0, 5, 8'hff);
    wreg(0, 6, 8'hff);
    check("p2 out", d2.out, 8'h0f);
    check("p2 oe", d2.oe, 8'hff);
    check("p2 pull", d2.pull, 8'hff);
    wreg(0, 6, 8'h00);
    check("p2 od oe", d2.oe, 8'hf0);
    rreg(0, 4, 8'h0f);
    // ----------------------------------------
    // port 1 lock
    // ----------------------------------------
    e1 = 8'hff;
    wreg(1, 0, 8'hf0);
    wreg(1, 0, 8'h00);
    rreg(1, 0, 8'hf0);
    wreg(0, 1, 8'hff);
    rreg(0, 1, 8'h5f);
    wreg(0, 2, 8'h00);
    rreg(0, 2, 8'h50);
    wreg(0, 0, 8'h00);
    settle();
    rreg(0, 0, 8'h50);
    // ----------------------------------------
    // pin 0 routed onto pin 1
    // ----------------------------------------
    wreg(0, 1, 8'h02);
    wreg(0, 2, 8'h02);
    wreg(1, 2, 8'h01);
    settle();
    check("route low act", {6'h00, d1.oe[1], d1.out[1]}, 8'h03);
    x1 = 8'h01;
    settle();
    check("route idle", {6'h00, d1.oe[1], d1.out[1]}, 8'h02);
    wreg(1, 1, 8'h01);
    settle();
    check("route high act", {6'h00, d1.oe[1], d1.out[1]}, 8'h03);
    wreg(0, 2, 8'h50);
    settle();
    check("route od float", {6'h00, d1.oe[1], d1.out[1]}, 8'h01);
    wreg(1, 2, 8'h00);
    settle();
    check("route off", {6'h00, d1.oe[1], d1.out[1]}, 8'h02);
    // ----------------------------------------
    // hard reset clears the lock
    // ----------------------------------------
    @(negedge ref_clk);
    rst = 1;
    repeat (3) @(negedge ref_clk);
    rst = 0;
    settle();
    rreg(1, 0, 8'h00);
    rreg(0, 1, 8'h00);
    wreg(0, 1, 8'hff);
    rreg(0, 1, 8'hff);
    print_verdict();
  end
endmodule
